// *** teach_io_consts.vh ***
// constants for the teach and digital IO pin configuration bank
// Behaviour
// RULE_01: Teach storage value 0 keeps taught values in non-volatile memory and value 1 only while supply is on.
// RULE_02: The host is expected to leave teach storage at the non-volatile setting in most applications.
// RULE_03: Teach sensitivity accepts codes 0 to 3 (high, medium, low reserve, transparent media) with default 0.
// RULE_04: A higher function reserve gives lower detection sensitivity and a lower reserve gives higher sensitivity.
// RULE_05: Switching threshold is a percentage 10 to 98, default 75, where 50 percent matches reserve code 2.
// RULE_06: One common switching level drives all IO pins negative (0) or positive (1), default positive.
// RULE_07: Pins 2, 5, 6 and 7 are configurable on the point-to-point variant, only pins 2 and 5 otherwise.
// RULE_08: A pin record holds direction at bit 24 (0 out, 1 in) and input function at bit 8 (0 off, 1 trigger, 2 teach).
// RULE_09: A pin behaviour field at bit 16 gives light switching for 0 and inverted dark switching for 1, default 0.
// RULE_10: A pin output function at bit 0 selects off, switching output, warning output or trigger output.
// RULE_11: The teach record is 32 bits with storage at bit 16, sensitivity at bit 8 and threshold at bit 0.
// RULE_12: Multi-field records are accessed whole only, and every field of a written record updates together.
// RULE_13: A write with any field outside its range is rejected and the old value is kept.
`ifndef TEACH_IO_CONSTS_VH
`define TEACH_IO_CONSTS_VH

// parameter indices
`define IDX_IO_LEVEL    8'h4D
`define IDX_TEACH       8'h4F
`define IDX_PIN2        8'h50
`define IDX_PIN5        8'h51
`define IDX_PIN6        8'h52
`define IDX_PIN7        8'h53

// field positions inside a 32-bit record
`define FLD_TEACH_STORE 16
`define FLD_TEACH_SENS  8
`define FLD_TEACH_THR   0
`define FLD_PIN_DIR     24
`define FLD_PIN_INV     16
`define FLD_PIN_INFN    8
`define FLD_PIN_OUTFN   0

// field limits
`define MAX_STORE       8'h01
`define MAX_SENS        8'h03
`define MIN_THR         8'h0A
`define MAX_THR         8'h62
`define MAX_LEVEL       8'h01
`define MAX_DIR         8'h01
`define MAX_INV         8'h01
`define MAX_INFN        8'h02
`define MAX_OUTFN       8'h03

// reset values
`define RST_LEVEL       8'h01
`define RST_TEACH       32'h0000004B
`define RST_PIN         32'h00000000

// function codes
`define INFN_TRIG       8'h01
`define INFN_TEACH      8'h02
`define OUTFN_SWITCH    8'h01
`define OUTFN_WARN      8'h02
`define OUTFN_TRIG      8'h03

`endif

// *** pin_io_stage.v ***
// one configurable IO pin: record check and pin drive/sense
`include "teach_io_consts.vh"
`default_nettype none
module pin_io_stage (
    // candidate record for a write, and the stored record
    input  wire [31:0] wrRecord,
    input  wire [31:0] cfgRecord,
    // common level and internal signals
    input  wire        positiveLevel,
    input  wire        switchState,
    input  wire        warnState,
    input  wire        trigState,
    input  wire        pinIn,
    // results
    output wire        recordOk,
    output wire        pinOut,
    output wire        pinOe,
    output wire        trigInActive,
    output wire        teachInActive
);
    wire [7:0] wDir   = wrRecord[`FLD_PIN_DIR +: 8];
    wire [7:0] wInv   = wrRecord[`FLD_PIN_INV +: 8];
    wire [7:0] wInFn  = wrRecord[`FLD_PIN_INFN +: 8];
    wire [7:0] wOutFn = wrRecord[`FLD_PIN_OUTFN +: 8];
    wire [7:0] cDir   = cfgRecord[`FLD_PIN_DIR +: 8];
    wire [7:0] cInv   = cfgRecord[`FLD_PIN_INV +: 8];
    wire [7:0] cInFn  = cfgRecord[`FLD_PIN_INFN +: 8];
    wire [7:0] cOutFn = cfgRecord[`FLD_PIN_OUTFN +: 8];
    reg        logicOut;

    // every field in range, else the whole record is refused
    assign recordOk = (wDir <= `MAX_DIR) && (wInv <= `MAX_INV) &&
                      (wInFn <= `MAX_INFN) && (wOutFn <= `MAX_OUTFN); // RULE_13

    // output source selection
    always @* begin
        if (cOutFn == `OUTFN_SWITCH) begin
            logicOut = switchState; // RULE_10
        end else if (cOutFn == `OUTFN_WARN) begin
            logicOut = warnState; // RULE_10
        end else if (cOutFn == `OUTFN_TRIG) begin
            logicOut = trigState; // RULE_10
        end else begin
            logicOut = 1'b0;
        end
    end

    // dark switching inverts, NPN pulls low when active
    assign pinOut = (logicOut ^ cInv[0]) ^ ~positiveLevel; // RULE_09
    assign pinOe  = (cDir == 8'h00) && (cOutFn != 8'h00); // RULE_08
    // input active level follows the common switching level
    assign trigInActive  = (cDir == 8'h01) && (cInFn == `INFN_TRIG) && (pinIn ^ ~positiveLevel); // RULE_08
    assign teachInActive = (cDir == 8'h01) && (cInFn == `INFN_TEACH) && (pinIn ^ ~positiveLevel); // RULE_08
endmodule // pin_io_stage
`default_nettype wire

// *** teach_io_config.v ***
// teach settings and digital IO pin configuration bank
`include "teach_io_consts.vh"
`default_nettype none
module teach_io_config (
    // clock and reset
    input  wire        ref_clk,
    input  wire        reset,
    // device variant: 1 point-to-point link, 0 analog or fieldbus
    input  wire        pointToPoint,
    // parameter access port
    input  wire        paramReq,
    input  wire        paramWr,
    input  wire [7:0]  paramIdx,
    input  wire [7:0]  paramSub,
    input  wire [31:0] paramWrData,
    output reg  [31:0] paramRdData_q,
    output reg         paramAck_q,
    output reg         paramErr_q,
    // teach settings to the measurement core
    output reg         teachVolatile_q,
    output reg  [1:0]  sensRank_q,
    output reg         transparentMedia_q,
    output reg  [6:0]  thresholdPct_q,
    // internal signals routed to pins
    input  wire        switchState,
    input  wire        warnState,
    input  wire        trigState,
    // pins 2, 5, 6, 7 in bit order 0..3
    input  wire [3:0]  pinIn,
    output reg  [3:0]  pinOut_q,
    output reg  [3:0]  pinOe_q,
    output reg         trigIn_q,
    output reg         teachIn_q
);
    reg  [7:0]   levelReg_q;
    reg  [31:0]  teachReg_q;
    reg  [127:0] pinRegs_q;
    wire [3:0]   pinRecOk;
    wire [3:0]   pinOutW;
    wire [3:0]   pinOeW;
    wire [3:0]   trigInW;
    wire [3:0]   teachInW;
    wire [3:0]   pinAllowed;
    wire         teachOk;
    wire [7:0]   wStore = paramWrData[`FLD_TEACH_STORE +: 8];
    wire [7:0]   wSens  = paramWrData[`FLD_TEACH_SENS +: 8];
    wire [7:0]   wThr   = paramWrData[`FLD_TEACH_THR +: 8];
    reg          idxKnown;
    reg          wrOk;
    reg  [31:0]  rdValue;
    reg  [2:0]   pinSel;
    wire         subOk;
    wire         takeReq;
    wire         storeReq;

    // pin slot for an index, 3'h4 when not a pin record
    function [2:0] pinSlot;
        input [7:0] idx;
        begin
            if (idx == `IDX_PIN2) begin
                pinSlot = 3'h0;
            end else if (idx == `IDX_PIN5) begin
                pinSlot = 3'h1;
            end else if (idx == `IDX_PIN6) begin
                pinSlot = 3'h2;
            end else if (idx == `IDX_PIN7) begin
                pinSlot = 3'h3;
            end else begin
                pinSlot = 3'h4;
            end
        end
    endfunction

    // pins 6 and 7 exist only on the point-to-point variant
    assign pinAllowed = {pointToPoint, pointToPoint, 2'b11}; // RULE_07

    // teach record range check, storage 0/1, sensitivity 0..3, threshold 10..98
    assign teachOk = (wStore <= `MAX_STORE) && (wSens <= `MAX_SENS) &&
                     (wThr >= `MIN_THR) && (wThr <= `MAX_THR); // RULE_13

    // one stage per pin; each checks the candidate write record and drives its pin from the stored record
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : pinStage
            pin_io_stage stage (
                .wrRecord      (paramWrData),
                .cfgRecord     (pinRegs_q[gi*32 +: 32]),
                .positiveLevel (levelReg_q[0]),
                .switchState   (switchState),
                .warnState     (warnState),
                .trigState     (trigState),
                .pinIn         (pinIn[gi]),
                .recordOk      (pinRecOk[gi]),
                .pinOut        (pinOutW[gi]),
                .pinOe         (pinOeW[gi]),
                .trigInActive  (trigInW[gi]),
                .teachInActive (teachInW[gi])
            );
        end
    endgenerate

    // index decode: which record, and whether this variant has it
    always @* begin
        pinSel   = pinSlot(paramIdx);
        idxKnown = 1'b0;
        if (paramIdx == `IDX_IO_LEVEL) begin
            idxKnown = 1'b1;
        end else if (paramIdx == `IDX_TEACH) begin
            idxKnown = 1'b1;
        end else if (pinSel != 3'h4) begin
            idxKnown = pinAllowed[pinSel[1:0]]; // RULE_07
        end
    end

    // write check: every field of the candidate record in range
    always @* begin
        wrOk = 1'b0;
        if (paramIdx == `IDX_IO_LEVEL) begin
            wrOk = (paramWrData[7:0] <= `MAX_LEVEL) && (paramWrData[31:8] == 24'h000000); // RULE_13
        end else if (paramIdx == `IDX_TEACH) begin
            wrOk = teachOk; // RULE_13
        end else if (pinSel != 3'h4) begin
            wrOk = pinRecOk[pinSel[1:0]]; // RULE_13
        end
    end

    // read mux; the level byte reads back zero-extended
    always @* begin
        rdValue = 32'h00000000;
        if (paramIdx == `IDX_IO_LEVEL) begin
            rdValue = {24'h000000, levelReg_q};
        end else if (paramIdx == `IDX_TEACH) begin
            rdValue = teachReg_q;
        end else if (pinSel != 3'h4) begin
            rdValue = pinRegs_q[pinSel[1:0]*32 +: 32];
        end
    end

    // a request is taken whole or refused whole, so no half-written record exists
    assign subOk    = (paramSub == 8'h00); // RULE_12
    assign takeReq  = paramReq && idxKnown && subOk && (!paramWr || wrOk); // RULE_13
    assign storeReq = takeReq && paramWr;

    // answer: one pulse per request, read data held until the next accepted read
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            paramRdData_q <= 32'h00000000;
            paramAck_q    <= 1'b0;
            paramErr_q    <= 1'b0;
        end else begin
            paramAck_q <= takeReq;
            paramErr_q <= paramReq && !takeReq; // RULE_12
            if (takeReq && !paramWr) begin
                paramRdData_q <= rdValue;
            end
        end
    end

    // common switching level for all pins
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            levelReg_q <= `RST_LEVEL; // RULE_06
        end else if (storeReq && paramIdx == `IDX_IO_LEVEL) begin
            levelReg_q <= paramWrData[7:0]; // RULE_06
        end
    end

    // teach record; upper byte is unused and reads as zero
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            teachReg_q <= `RST_TEACH; // RULE_03
        end else if (storeReq && paramIdx == `IDX_TEACH) begin
            teachReg_q <= {8'h00, paramWrData[23:0]}; // RULE_11
        end
    end

    // pin records; a refused write leaves the old record in place
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            pinRegs_q <= {4{`RST_PIN}};
        end else if (storeReq && pinSel != 3'h4) begin
            pinRegs_q[pinSel[1:0]*32 +: 32] <= paramWrData; // RULE_12
        end
    end

    // decoded teach settings; rank 0 is least sensitive (highest reserve)
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            teachVolatile_q    <= 1'b0;
            sensRank_q         <= 2'h0;
            transparentMedia_q <= 1'b0;
            thresholdPct_q     <= 7'h4B;
        end else begin
            teachVolatile_q    <= teachReg_q[`FLD_TEACH_STORE]; // RULE_01
            sensRank_q         <= teachReg_q[`FLD_TEACH_SENS +: 2]; // RULE_04
            transparentMedia_q <= (teachReg_q[`FLD_TEACH_SENS +: 8] == `MAX_SENS); // RULE_03
            thresholdPct_q     <= teachReg_q[`FLD_TEACH_THR +: 7]; // RULE_05
        end
    end

    // pin drive, registered; absent pins stay released
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            pinOut_q <= 4'h0;
            pinOe_q  <= 4'h0;
        end else begin
            pinOut_q <= pinOutW & pinAllowed;
            pinOe_q  <= pinOeW & pinAllowed; // RULE_07
        end
    end

    // input sensing, registered; inputs of absent pins are ignored
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            trigIn_q  <= 1'b0;
            teachIn_q <= 1'b0;
        end else begin
            trigIn_q  <= |(trigInW & pinAllowed); // RULE_08
            teachIn_q <= |(teachInW & pinAllowed); // RULE_08
        end
    end
endmodule // teach_io_config
`default_nettype wire

// *** teach_io_config_monitor.sv ***
// assertion checker for the teach and IO configuration bank
`default_nettype none
module teach_io_config_monitor (
    // clock, reset, variant
    input wire logic        ref_clk,
    input wire logic        reset,
    input wire logic        pointToPoint,
    // access port
    input wire logic        paramReq,
    input wire logic        paramWr,
    input wire logic [7:0]  paramIdx,
    input wire logic [7:0]  paramSub,
    input wire logic [31:0] paramWrData,
    input wire logic        paramAck_q,
    input wire logic        paramErr_q,
    // decoded teach outputs
    input wire logic        teachVolatile_q,
    input wire logic [1:0]  sensRank_q,
    input wire logic        transparentMedia_q,
    input wire logic [6:0]  thresholdPct_q
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    // whole-record write to the teach record
    wire logic wrReq = paramReq && paramWr && paramSub == 8'h00;
    wire logic teachWr = wrReq && paramIdx == 8'h4F;
    sequence teach_taken;
        teachWr ##1 paramAck_q;
    endsequence
    one_answer_a:
        assert property (paramReq |=> paramAck_q != paramErr_q) else $error("no single answer");
    sub_refused_a:
        assert property (paramReq && paramSub != 8'h00 |=> paramErr_q) else $error("sub access taken");
    thr_range_a:
        assert property (teachWr && (paramWrData[7:0] < 8'h0A || paramWrData[7:0] > 8'h62) |=> paramErr_q)
        else $error("threshold taken");
    sens_range_a:
        assert property (teachWr && paramWrData[15:8] > 8'h03 |=> paramErr_q) else $error("sensitivity taken");
    store_range_a:
        assert property (teachWr && paramWrData[23:16] > 8'h01 |=> paramErr_q) else $error("storage taken");
    level_range_a:
        assert property (wrReq && paramIdx == 8'h4D && paramWrData > 32'h1 |=> paramErr_q) else $error("level taken");
    variant_pins_a:
        assert property (paramReq && !pointToPoint && paramIdx[7:1] == 7'h29 |=> paramErr_q) else $error("pin taken");
    teach_update_a:
        assert property (teach_taken |=> ($past(paramWrData, 2) & 32'h00FFFFFF) ==
            {15'h0, teachVolatile_q, 6'h0, sensRank_q, 1'b0, thresholdPct_q}) else $error("teach fields stale");
    transparent_a:
        assert property (transparentMedia_q == (sensRank_q == 2'h3)) else $error("transparent flag wrong");
endmodule // teach_io_config_monitor
bind teach_io_config teach_io_config_monitor mon (.ref_clk, .reset, .pointToPoint, .paramReq, .paramWr, .paramIdx,
    .paramSub, .paramWrData, .paramAck_q, .paramErr_q, .teachVolatile_q, .sensRank_q, .transparentMedia_q,
    .thresholdPct_q);
`default_nettype wire

// *** param_master.sv ***
// parameter master model for the configuration access port
`default_nettype none
module param_master (
    // clock and answer
    input  wire logic        ref_clk,
    input  wire logic        paramAck_q,
    input  wire logic        paramErr_q,
    input  wire logic [31:0] paramRdData_q,
    // request lines
    output var  logic        paramReq,
    output var  logic        paramWr,
    output var  logic [7:0]  paramIdx,
    output var  logic [7:0]  paramSub,
    output var  logic [31:0] paramWrData
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {paramReq, paramWr, paramIdx, paramSub, paramWrData} = 50'h0;
    // one record per access; entered just after an edge, answer read after the taking edge
    task automatic xfer(input logic w, input logic [7:0] idx, sub, input logic [31:0] d,
                        output logic [1:0] resp, output logic [31:0] rd);
        {paramReq, paramWr, paramIdx, paramSub, paramWrData} = {1'b1, w, idx, sub, d};
        @(posedge ref_clk);
        #1;
        resp = {paramErr_q, paramAck_q};
        rd = paramRdData_q;
    endtask
    // released lines carry the inverse so a stale copy cannot pass
    task automatic rel();
        {paramReq, paramWr, paramIdx, paramSub, paramWrData} = ~{1'b1, paramWr, paramIdx, paramSub, paramWrData};
        @(posedge ref_clk);
        #1;
    endtask
endmodule // param_master
`default_nettype wire

// *** teach_io_config_bench.sv ***
// self-checking bench for the teach and IO configuration bank
`include "teach_io_consts.vh"
`default_nettype none
module teach_io_config_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        ref_clk = 1'b0;
    logic        reset = 1'b1;
    logic        pointToPoint = 1'b1;
    logic        switchState = 1'b1, warnState = 1'b0, trigState = 1'b0;
    logic [3:0]  pinIn = 4'h4;
    logic        paramReq, paramWr, paramAck_q, paramErr_q;
    logic        teachVolatile_q, transparentMedia_q, trigIn_q, teachIn_q;
    logic [7:0]  paramIdx, paramSub;
    logic [31:0] paramWrData, paramRdData_q, rdv;
    logic [1:0]  sensRank_q, resp;
    logic [6:0]  thresholdPct_q;
    logic [3:0]  pinOut_q, pinOe_q;
    logic [31:0] badPin [4] = '{32'h02000000, 32'h00020000, 32'h00000300, 32'h00000004};
    int          errTotal = 0;
    int          samplesChecked = 0;
    always #20 ref_clk = ~ref_clk;
    teach_io_config dut (.ref_clk, .reset, .pointToPoint, .paramReq, .paramWr, .paramIdx, .paramSub, .paramWrData,
        .paramRdData_q, .paramAck_q, .paramErr_q, .teachVolatile_q, .sensRank_q, .transparentMedia_q, .thresholdPct_q,
        .switchState, .warnState, .trigState, .pinIn, .pinOut_q, .pinOe_q, .trigIn_q, .teachIn_q);
    param_master master (.ref_clk, .paramAck_q, .paramErr_q, .paramRdData_q, .paramReq, .paramWr, .paramIdx,
        .paramSub, .paramWrData);
    task automatic chk(input logic [31:0] got, exp);
        samplesChecked++;
        if (got !== exp) begin
            errTotal++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // answer 2'h1 is accepted, 2'h2 refused
    task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic [1:0] exp);
        master.xfer(1'b1, idx, 8'h00, d, resp, rdv);
        chk({30'h0, resp}, {30'h0, exp});
    endtask
    task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
        master.xfer(1'b0, idx, 8'h00, 32'h0, resp, rdv);
        chk({30'h0, resp}, 32'h1);
        chk(rdv, exp);
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", samplesChecked, errTotal);
        if (errTotal == 0 && samplesChecked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // pins settle one cycle after their record, so wait an idle cycle first
    task automatic pins(input logic [31:0] exp);
        master.rel();
        @(posedge ref_clk);
        #1;
        chk({22'h0, pinOe_q, pinOut_q & pinOe_q, trigIn_q, teachIn_q}, exp);
    endtask
    // run needs about 46 cycles
    initial begin
        #20000;
        errTotal++;
        give_verdict();
    end
    initial begin
        repeat (8) @(posedge ref_clk);
        #1;
        reset = 1'b0;
        rd(`IDX_TEACH, 32'h0000004B);
        rd(`IDX_IO_LEVEL, 32'h00000001);
        rd(`IDX_PIN7, 32'h00000000);
        wr(`IDX_TEACH, 32'h00010362, 2'h1);
        wr(`IDX_TEACH, 32'h00000309, 2'h2);
        wr(`IDX_TEACH, 32'h00000463, 2'h2);
        wr(`IDX_TEACH, 32'h00020062, 2'h2);
        rd(`IDX_TEACH, 32'h00010362);
        chk({21'h0, teachVolatile_q, transparentMedia_q, sensRank_q, thresholdPct_q}, 32'h000007E2);
        wr(`IDX_TEACH, 32'hFF00010A, 2'h1);
        rd(`IDX_TEACH, 32'h0000010A);
        master.xfer(1'b0, `IDX_TEACH, 8'h03, 32'h0, resp, rdv);
        chk({30'h0, resp}, 32'h2);
        wr(8'h4E, 32'h0, 2'h2);
        wr(`IDX_IO_LEVEL, 32'h00000002, 2'h2);
        wr(`IDX_IO_LEVEL, 32'h00000000, 2'h1);
        for (int i = 0; i < 4; i++) wr(`IDX_PIN2 + 8'(i), badPin[i], 2'h2);
        rd(`IDX_PIN2, 32'h0);
        wr(`IDX_PIN2, 32'h00000001, 2'h1);
        wr(`IDX_PIN5, 32'h00010002, 2'h1);
        wr(`IDX_PIN6, 32'h00000003, 2'h1);
        wr(`IDX_PIN7, 32'h01000200, 2'h1);
        pins(32'h1D1);
        warnState = 1'b1;
        wr(`IDX_PIN6, 32'h01000100, 2'h1);
        wr(`IDX_IO_LEVEL, 32'h00000001, 2'h1);
        pins(32'h0C6);
        // second reset into the reduced-pin variant
        reset = 1'b1;
        pointToPoint = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        reset = 1'b0;
        wr(`IDX_PIN6, 32'h00000001, 2'h2);
        wr(`IDX_PIN7, 32'h00000001, 2'h2);
        wr(`IDX_PIN5, 32'h00000001, 2'h1);
        pins(32'h088);
        rd(`IDX_TEACH, 32'h0000004B);
        master.rel();
        give_verdict();
    end
endmodule // teach_io_config_bench
`default_nettype wire
